//--- bench/dfa_core_model.sv
// Core-side model of the dispatch logic that enters handlers.
// Assumes the bench drives exception requests; this only answers deliveries.
`timescale 1ns/100ps
module dfa_core_model
	import dfa_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Delivery seen and entry latency in cycles
	input  wire logic       dlv_valid,
	input  wire logic [3:0] delay,
	// Entry completion back to the arbiter
	output logic            entry_done
);
	logic [3:0] cnt_reg;

	// A new delivery restarts entry, so a nested one delays completion
	always_ff @(posedge clk) begin
		if (rst || dlv_valid)
			cnt_reg <= rst ? 4'h0 : delay;
		else if (cnt_reg != 4'h0)
			cnt_reg <= cnt_reg - 4'h1;
	end

	// One-cycle pulse on the last step of the count
	assign entry_done = (cnt_reg == 4'h1);
endmodule : dfa_core_model

//--- bench/double_fault_arbiter_test.sv
// Self-checking bench for the double-fault arbiter.
// Assumes the core model closes every handler entry on its own.
`timescale 1ns/100ps
module double_fault_arbiter_test
	import dfa_pkg::*;
;
	logic       clk                = 1'b0;
	logic       rst                = 1'b1;
	logic       exc_valid          = 1'b0;
	dfa_exc_t   exc_in             = '0;
	logic       nmi_req            = 1'b0;
	logic       init_req           = 1'b0;
	logic       nmi_handler_active = 1'b0;
	logic [3:0] delay              = 4'h1;
	logic       entry_done;
	logic       dlv_valid;
	logic       shutdown_cycle;
	logic       halted;
	dfa_dlv_t   dlv;
	int         fail_count         = 0;
	int         n_tests            = 0;
	// Contributory first, then page, then benign except 09, which remaps to contributory
	logic [7:0] vt [16] = '{8'h00, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h01, 8'h02,
		8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h10, 8'h11, 8'h12};

	always #2.5 clk = ~clk;

	dfa_arbiter i_dfa_arbiter (.clk(clk), .rst(rst), .exc_valid(exc_valid), .exc_in(exc_in),
		.entry_done(entry_done), .nmi_req(nmi_req), .init_req(init_req),
		.nmi_handler_active(nmi_handler_active), .dlv_valid(dlv_valid), .dlv(dlv),
		.shutdown_cycle(shutdown_cycle), .halted(halted));
	dfa_core_model i_dfa_core_model (.clk(clk), .rst(rst), .dlv_valid(dlv_valid),
		.delay(delay), .entry_done(entry_done));

	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict

	// Flags are {soft_int, ext_irq, prefetch, fpu_xfer}
	function automatic logic [7:0] vexp(logic [7:0] v, logic [3:0] fl);
		return (fl[0] || (v == 8'h09 && !fl[3])) ? 8'h0D : v;
	endfunction : vexp

	function automatic int cls(logic [7:0] v, logic [3:0] fl);
		logic [7:0] r;
		r = vexp(v, fl);
		if (fl[3] || fl[2])
			return 1;
		if (r == 8'h00 || (r >= 8'h0A && r <= 8'h0D))
			return 2;
		return (r == 8'h0E) ? 4 : 1;
	endfunction : cls

	task automatic send(logic [7:0] v, logic [3:0] fl);
		@(posedge clk);
		exc_valid <= 1'b1;
		exc_in    <= dfa_exc_t'({v, fl});
		@(posedge clk);
		exc_valid <= 1'b0;
		#1;
	endtask : send

	task automatic do_reset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		#1;
		check("reset outputs", {dlv_valid, shutdown_cycle, halted, dlv.vector}, 0);
	endtask : do_reset

	// Lone requests from idle with a prompt core
	task automatic t_serial;
		logic [7:0] sv [7] = '{8'h03, 8'h09, 8'h09, 8'h14, 8'h00, 8'h0E, 8'h20};
		logic [3:0] sf [7] = '{4'h0, 4'h0, 4'h8, 4'h1, 4'h0, 4'h0, 4'h4};
		delay = 4'h1;
		for (int i = 0; i < 7; i++) begin
			send(sv[i], sf[i]);
			check("single valid", dlv_valid, 1'h1);
			check("single vector", dlv.vector, vexp(sv[i], sf[i]));
			check("single abort", dlv.abort, 1'h0);
			@(posedge clk);
			#1;
			check("single pulse", dlv_valid, 1'h0);
		end
		$display("test serial done");
	endtask : t_serial

	// Second request while the first handler is still being entered
	task automatic pair(logic [7:0] f, logic [7:0] s, logic [3:0] fl, logic [3:0] ff = 4'h0);
		logic       dbl;
		int         fc;
		logic [7:0] ev;
		repeat (10) @(posedge clk);
		fc  = ff[1] ? 1 : cls(f, ff);
		dbl = (fc == 2 && cls(s, fl) == 2 || fc == 4 && cls(s, fl) != 1) && !fl[1];
		ev  = dbl ? 8'h08 : vexp(s, fl);
		send(f, ff);
		send(s, fl);
		check("pair valid", dlv_valid, 1'h1);
		check("pair vector", dlv.vector, ev);
		check("pair abort", dlv.abort, dbl);
		if (dbl) begin
			check("dbl code", dlv.error_code, 32'h0);
			check("dbl flags", {dlv.has_error, dlv.ip_undefined}, 2'h3);
		end
	endtask : pair

	task automatic t_pairs;
		delay = 4'h6;
		for (int i = 0; i < 16; i++) begin
			pair(8'h00, vt[i], 4'h0);
			pair(8'h0E, vt[i], 4'h0);
			pair(8'h03, vt[i], 4'h0);
		end
		pair(8'h00, 8'h0D, 4'h8);
		pair(8'h0E, 8'h0E, 4'h4);
		pair(8'h0E, 8'h0D, 4'h2);
		pair(8'h0C, 8'h0E, 4'h1);
		pair(8'h0E, 8'h0D, 4'h0, 4'h2);
		pair(8'h00, 8'h0C, 4'h0, 4'h2);
		$display("test pairs done");
	endtask : t_pairs

	// Fault during double-fault entry, then a release attempt
	task automatic t_shutdown(logic lock, int how);
		@(posedge clk);
		nmi_handler_active <= lock;
		pair(8'h0D, 8'h0D, 4'h0);
		send(8'h03, 4'h0);
		check("shutdown cycle", {shutdown_cycle, halted, dlv_valid}, 3'h6);
		send(8'h0D, 4'h0);
		check("halt ignores", {shutdown_cycle, halted, dlv_valid}, 3'h2);
		@(posedge clk);
		nmi_req  <= (how != 1);
		init_req <= (how != 0);
		@(posedge clk);
		nmi_req  <= 1'b0;
		init_req <= 1'b0;
		nmi_handler_active <= 1'b0;
		#1;
		if (lock) begin
			check("locked halt", {halted, dlv_valid}, 2'h2);
			do_reset();
		end else if (how != 0)
			check("init exit", {halted, dlv_valid}, 2'h0);
		else
			check("nmi exit", {halted, dlv_valid, dlv.vector}, 10'h102);
		$display("test shutdown %0d %0d done", lock, how);
	endtask : t_shutdown

	initial begin
		do_reset();
		t_serial();
		t_pairs();
		t_shutdown(1'b0, 0);
		t_shutdown(1'b0, 1);
		t_shutdown(1'b0, 2);
		t_shutdown(1'b1, 2);
		print_verdict();
	end

	// Hang guard
	initial begin
		#200us;
		fail_count++;
		$display("[ERR] run time expected end seen timeout");
		print_verdict();
	end
endmodule : double_fault_arbiter_test

//--- include/dfa_pkg.sv
// Constants and carrier types for the double-fault arbiter.
// Assumes one core clock and a synchronous active-high reset.
package dfa_pkg;

	// Exception classes, one-hot
	typedef enum logic [2:0] {
		DFA_CLS_BENIGN  = 3'h1,
		DFA_CLS_CONTRIB = 3'h2,
		DFA_CLS_PAGE    = 3'h4
	} dfa_class_t;

	// Arbiter states, one-hot
	typedef enum logic [3:0] {
		DFA_ST_IDLE      = 4'h1,
		DFA_ST_ENTER     = 4'h2,
		DFA_ST_DBL_ENTER = 4'h4,
		DFA_ST_SHUTDOWN  = 4'h8
	} dfa_state_t;

	// Vector numbers the arbiter decodes or issues
	localparam logic [7:0]  DFA_VEC_DIVIDE  = 8'h00;
	localparam logic [7:0]  DFA_VEC_NMI     = 8'h02;
	localparam logic [7:0]  DFA_VEC_DOUBLE  = 8'h08;
	localparam logic [7:0]  DFA_VEC_CSO     = 8'h09;
	localparam logic [7:0]  DFA_VEC_TASKSEG = 8'h0A;
	localparam logic [7:0]  DFA_VEC_PROT    = 8'h0D;
	localparam logic [7:0]  DFA_VEC_PAGE    = 8'h0E;
	localparam logic [31:0] DFA_DBL_ERRCODE = 32'h0000_0000;

	// Exception request from the pipeline
	typedef struct packed {
		logic [7:0] vector;
		logic       soft_int;
		logic       ext_irq;
		logic       prefetch;
		logic       fpu_xfer;
	} dfa_exc_t;

	// Delivery to the handler-dispatch logic
	typedef struct packed {
		logic [7:0]  vector;
		logic        has_error;
		logic [31:0] error_code;
		logic        abort;
		logic        ip_undefined;
	} dfa_dlv_t;

	// Values after reset
	localparam dfa_dlv_t   DFA_DLV_RESET = '0;
	localparam dfa_class_t DFA_CLS_RESET = DFA_CLS_BENIGN;
	localparam dfa_state_t DFA_ST_RESET  = DFA_ST_IDLE;

endpackage : dfa_pkg

//--- logic/dfa_arbiter.sv
// Double-fault arbiter: resolves nested exceptions during handler entry.
// Assumes the pipeline presents at most one exception per cycle and pulses
// entry_done when the dispatch logic has finished entering a handler.
`timescale 1ns/100ps
module dfa_arbiter
	import dfa_pkg::*;
(
	// Clock and reset
	input  wire logic     clk,
	input  wire logic     rst,
	// Exception requests from the pipeline
	input  wire logic     exc_valid,
	input  dfa_exc_t      exc_in,
	// Dispatch progress and release events
	input  wire logic     entry_done,
	input  wire logic     nmi_req,
	input  wire logic     init_req,
	input  wire logic     nmi_handler_active,
	// Delivery to dispatch
	output logic          dlv_valid,
	output dfa_dlv_t      dlv,
	// Shutdown signalling
	output logic          shutdown_cycle,
	output logic          halted
);

	dfa_state_t state_reg, state_next;
	dfa_class_t cls_reg, cls_next;
	logic       lock_reg, lock_next;
	logic       dv_reg, dv_next;
	dfa_dlv_t   dlv_reg, dlv_next;
	logic       sd_reg, sd_next;
	logic       halt_reg;
	dfa_class_t new_cls;
	logic [7:0] new_vec;

	// Classify the arriving exception
	dfa_classify u_classify (
		.exc    (exc_in),
		.cls    (new_cls),
		.vector (new_vec)
	);

	// Pairing decision; prefetch faults never pair up
	wire first_contrib = cls_reg == DFA_CLS_CONTRIB;
	wire first_page    = cls_reg == DFA_CLS_PAGE;
	wire sec_contrib   = new_cls == DFA_CLS_CONTRIB;
	wire sec_page      = new_cls == DFA_CLS_PAGE;
	wire dbl_pair      = !exc_in.prefetch &&
		((first_contrib && sec_contrib) ||
		 (first_page && (sec_contrib || sec_page)));

	// A prefetch fault is held as benign, so it cannot open a pair either
	wire dfa_class_t held_cls = exc_in.prefetch ? DFA_CLS_BENIGN : new_cls;

	// Delivery words
	wire dfa_dlv_t serial_dlv = '{vector: new_vec, has_error: 1'b0,
		error_code: '0, abort: 1'b0, ip_undefined: 1'b0};
	wire dfa_dlv_t dbl_dlv = '{vector: DFA_VEC_DOUBLE, has_error: 1'b1,
		error_code: DFA_DBL_ERRCODE, abort: 1'b1, ip_undefined: 1'b1};
	wire dfa_dlv_t nmi_dlv = '{vector: DFA_VEC_NMI, has_error: 1'b0,
		error_code: '0, abort: 1'b0, ip_undefined: 1'b0};

	// Shutdown can be left by NMI or INIT only when it was not entered inside an NMI handler
	wire release_ok = !lock_reg;

	// State machine; an exception in the entry_done cycle counts as nested
	always_comb begin
		state_next = state_reg;
		cls_next   = cls_reg;
		lock_next  = lock_reg;
		dv_next    = 1'b0;
		dlv_next   = dlv_reg;
		sd_next    = 1'b0;
		unique case (state_reg)
			DFA_ST_IDLE: begin
				if (exc_valid) begin
					dv_next    = 1'b1;
					dlv_next   = serial_dlv;
					cls_next   = held_cls;
					state_next = DFA_ST_ENTER;
				end
			end
			DFA_ST_ENTER: begin
				if (exc_valid && dbl_pair) begin
					dv_next    = 1'b1;
					dlv_next   = dbl_dlv;
					state_next = DFA_ST_DBL_ENTER;
				end else if (exc_valid) begin
					dv_next    = 1'b1;
					dlv_next   = serial_dlv;
					cls_next   = held_cls;
				end else if (entry_done) begin
					state_next = DFA_ST_IDLE;
				end
			end
			DFA_ST_DBL_ENTER: begin
				if (exc_valid) begin
					sd_next    = 1'b1;
					lock_next  = nmi_handler_active;
					state_next = DFA_ST_SHUTDOWN;
				end else if (entry_done) begin
					state_next = DFA_ST_IDLE;
				end
			end
			DFA_ST_SHUTDOWN: begin
				// Further requests are ignored while halted
				if (init_req && release_ok) begin
					state_next = DFA_ST_IDLE;
				end else if (nmi_req && release_ok) begin
					dv_next    = 1'b1;
					dlv_next   = nmi_dlv;
					cls_next   = DFA_CLS_BENIGN;
					state_next = DFA_ST_ENTER;
				end
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= DFA_ST_RESET;
			cls_reg   <= DFA_CLS_RESET;
			lock_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			cls_reg   <= cls_next;
			lock_reg  <= lock_next;
		end
	end

	// Output registers; halted tracks the next state so it rises with the bus cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			dv_reg   <= 1'b0;
			dlv_reg  <= DFA_DLV_RESET;
			sd_reg   <= 1'b0;
			halt_reg <= 1'b0;
		end else begin
			dv_reg   <= dv_next;
			dlv_reg  <= dlv_next;
			sd_reg   <= sd_next;
			halt_reg <= state_next == DFA_ST_SHUTDOWN;
		end
	end

	assign dlv_valid      = dv_reg;
	assign dlv            = dlv_reg;
	assign shutdown_cycle = sd_reg;
	assign halted         = halt_reg;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_class_onehot: assert property ($onehot(cls_reg))
		else $error("held class not one-hot");

	a_contrib_pair_dbl: assert property (state_reg == DFA_ST_ENTER && exc_valid &&
		!exc_in.prefetch && first_contrib && sec_contrib
		|=> dlv_valid && dlv.vector == DFA_VEC_DOUBLE && state_reg == DFA_ST_DBL_ENTER)
		else $error("contributory pair did not give double fault");

	a_page_pair_dbl: assert property (state_reg == DFA_ST_ENTER && exc_valid &&
		!exc_in.prefetch && first_page && new_cls != DFA_CLS_BENIGN
		|=> dlv_valid && dlv.vector == DFA_VEC_DOUBLE)
		else $error("page fault pair did not give double fault");

	a_benign_serial: assert property (state_reg == DFA_ST_ENTER && exc_valid &&
		(cls_reg == DFA_CLS_BENIGN || new_cls == DFA_CLS_BENIGN)
		|=> dlv_valid && !dlv.abort && dlv.vector == $past(new_vec))
		else $error("benign pairing not handled serially");

	a_prefetch_excluded: assert property (state_reg == DFA_ST_ENTER && exc_valid &&
		exc_in.prefetch |=> dlv_valid && !dlv.abort)
		else $error("prefetch fault raised double fault");

	a_prefetch_held: assert property (state_reg == DFA_ST_IDLE && exc_valid &&
		exc_in.prefetch |=> cls_reg == DFA_CLS_BENIGN)
		else $error("prefetch fault held as pairing class");

	a_dbl_frame: assert property (dlv_valid && dlv.vector == DFA_VEC_DOUBLE
		|-> dlv.abort && dlv.has_error && dlv.error_code == DFA_DBL_ERRCODE &&
		dlv.ip_undefined)
		else $error("double fault frame wrong");

	a_shutdown_entry: assert property (state_reg == DFA_ST_DBL_ENTER && exc_valid
		|=> shutdown_cycle && halted && !dlv_valid ##1 !shutdown_cycle)
		else $error("shutdown entry wrong");

	a_shutdown_hold: assert property (halted && !nmi_req && !init_req
		|=> halted && !dlv_valid)
		else $error("left shutdown without release");

	a_nmi_lock: assert property (halted && lock_reg |=> halted)
		else $error("NMI-locked shutdown released");

	a_nmi_exit: assert property (halted && !lock_reg && nmi_req && !init_req
		|=> !halted && dlv_valid && dlv.vector == DFA_VEC_NMI)
		else $error("NMI did not release shutdown");

	a_no_overrun: assert property (dlv_valid && dlv.vector == DFA_VEC_CSO
		|-> $past(exc_in.soft_int))
		else $error("vector 9 raised by hardware");

	a_xfer_to_prot: assert property (state_reg == DFA_ST_IDLE && exc_valid &&
		exc_in.fpu_xfer |=> dlv.vector == DFA_VEC_PROT)
		else $error("operand-transfer fault not on vector 13");

	a_class_held: assert property (state_reg == DFA_ST_ENTER && !exc_valid
		|=> cls_reg == $past(cls_reg))
		else $error("held class changed during entry");

	c_serial_pair: cover property (state_reg == DFA_ST_ENTER && exc_valid && !dbl_pair);
	c_double_fault: cover property (dlv_valid && dlv.vector == DFA_VEC_DOUBLE);
	c_shutdown_nmi: cover property (halted && !lock_reg ##1 !halted && dlv_valid);
	c_locked_halt: cover property (halted && lock_reg);

endmodule : dfa_arbiter

//--- logic/dfa_classify.sv
// Exception classifier: remaps the reserved overrun vector and sorts into classes.
// Assumes a combinational path from the request struct; no clock needed.
`timescale 1ns/100ps
module dfa_classify
	import dfa_pkg::*;
(
	// Request in
	input  dfa_exc_t   exc,
	// Decoded class and final vector
	output dfa_class_t cls,
	output logic [7:0] vector
);

	// Operand-transfer faults and vector 9 not raised as a software interrupt become protection faults
	wire remap_prot = exc.fpu_xfer || (!exc.soft_int && exc.vector == DFA_VEC_CSO);
	assign vector   = remap_prot ? DFA_VEC_PROT : exc.vector;

	// Software and external interrupts are benign whatever their number
	wire is_int     = exc.soft_int || exc.ext_irq;
	wire is_contrib = !is_int && (vector == DFA_VEC_DIVIDE ||
		(vector >= DFA_VEC_TASKSEG && vector <= DFA_VEC_PROT));
	wire is_page    = !is_int && vector == DFA_VEC_PAGE;

	// Exactly one class; all remaining vectors fall to benign
	assign cls = is_contrib ? DFA_CLS_CONTRIB :
		is_page ? DFA_CLS_PAGE : DFA_CLS_BENIGN;

endmodule : dfa_classify
